// >>> core/hima_consts.svh
// constants for the hold inputs and menu access block
// Notes on behaviour
// - control lines other than the holds need 200ms and act within 200ms.
// - digital hold freezes the display while asserted, same 200ms timing.
// - fast analogue hold acts on 0.1ms pulses within 0.1ms, drops on release.
// - fast analogue hold freezes both the display and the analogue output.
// - three independent signed five-digit passwords guard the menus.
// - defaults are 00001, 00002, 00003 opening user, calibration, config.
// - config menu runs on into calibration, calibration into user setup.
// - setup held one second in normal mode opens level one prompt.
// - up and down cycle the level prompt among levels one to three.
// - select takes the level and shows 00000 with the right digit flashing.
// - an open menu steps forward and back and selects the shown item.
// - enter takes the flashing digit and moves the flash one place left.
// - a wrong password abandons the menu and returns to normal mode.
`ifndef HIMA_CONSTS_SVH
`define HIMA_CONSTS_SVH
`define CLK_HZ 25000000
`define EXT_MIN_PULSE_MS 200
`define FAST_MIN_PULSE_US 100
`define SETUP_LONG_MS 1000
`define KEY_DEBOUNCE_MS 20
`define PW_USER_DEFAULT 21'h000001
`define PW_CAL_DEFAULT 21'h000002
`define PW_CFG_DEFAULT 21'h000003
`define PW_PROMPT 21'h000000
`define LEVEL_ONE 2'h1
`define LEVEL_THREE 2'h3
`define MENU_USER 2'h1
`define MENU_CAL 2'h2
`define MENU_CFG 2'h3
`define POS_RIGHT 3'h0
`define POS_LEFT 3'h4
`define DIGIT_MAX 4'h9
`define DIGIT_ZERO 4'h0
`endif

// >>> core/hima_core.sv
// hold input qualification and menu access sequencer
`timescale 1ns/1ps
`include "hima_consts.svh"
module hima_core #(
  parameter int unsigned EXT_QUAL_CYC =
    (`CLK_HZ / 1000) * `EXT_MIN_PULSE_MS / 2,
  parameter int unsigned FAST_QUAL_CYC =
    (`CLK_HZ / 1000000) * `FAST_MIN_PULSE_US / 2,
  parameter int unsigned KEY_QUAL_CYC = (`CLK_HZ / 1000) * `KEY_DEBOUNCE_MS,
  parameter int unsigned SETUP_LONG_CYC = (`CLK_HZ / 1000) * `SETUP_LONG_MS,
  parameter logic [3:0] CFG_ITEMS = 4'h4,
  parameter logic [3:0] CAL_ITEMS = 4'h8,
  parameter logic [3:0] USR_ITEMS = 4'h6
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // front panel keys and external lines, raw pins
  input wire hima_pkg::hima_keys_t i_keys,
  input wire hima_pkg::hima_ext_t i_ext,
  input wire logic i_ext_fast_hold,
  // password store load port
  input wire logic i_pw_wr,
  input wire logic [1:0] i_pw_sel,
  input wire hima_pkg::hima_pw_t i_pw_value,
  // qualified controls and holds
  output hima_pkg::hima_ext_t o_ext_func,
  output logic o_display_freeze,
  output logic o_analog_freeze,
  // menu access state
  output hima_pkg::hima_state_t o_state,
  output logic [1:0] o_level,
  output hima_pkg::hima_pw_t o_pw_entry,
  output logic [2:0] o_flash_pos,
  output logic [1:0] o_menu,
  output logic [3:0] o_item,
  output logic o_item_select,
  output logic o_access_denied
);
  localparam int SW = $clog2(SETUP_LONG_CYC + 1);
  wire hima_pkg::hima_keys_t key_lvl;
  hima_pkg::hima_keys_t key_prev_q;
  wire hima_pkg::hima_ext_t ext_lvl;
  logic fast_lvl;
  hima_pkg::hima_pw_t pw_q [1:3];
  logic [SW-1:0] setup_cnt_q;

  // ************************************************************
  // input qualification
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_key
      hima_qual #(.QUAL_CYC(KEY_QUAL_CYC)) u_key (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_pin(i_keys[g]),
        .o_level(key_lvl[g])
      );
    end
    for (g = 0; g < 4; g++)
    begin : g_ext
      hima_qual #(.QUAL_CYC(EXT_QUAL_CYC)) u_ext (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_pin(i_ext[g]),
        .o_level(ext_lvl[g])
      );
    end
  endgenerate

  hima_qual #(.QUAL_CYC(FAST_QUAL_CYC)) u_fast (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_ext_fast_hold),
    .o_level(fast_lvl)
  );

  // hold outputs: fast hold freezes display and analogue output
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_ext_func <= '0;
      o_display_freeze <= 1'b0;
      o_analog_freeze <= 1'b0;
    end
    else
    begin
      o_ext_func <= ext_lvl;
      o_display_freeze <= ext_lvl.reset || fast_lvl;
      o_analog_freeze <= fast_lvl;
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [3:0] last_item(input logic [1:0] menu);
    last_item = (menu == `MENU_CFG) ? CFG_ITEMS - 4'h1 :
                (menu == `MENU_CAL) ? CAL_ITEMS - 4'h1 : USR_ITEMS - 4'h1;
  endfunction : last_item

  // one step of a digit; the leftmost digit also walks through the sign
  function automatic hima_pkg::hima_pw_t step_digit(
    input hima_pkg::hima_pw_t v, input logic [2:0] pos, input logic up);
    logic [3:0] d;
    d = v.dig[pos];
    step_digit = v;
    if (pos != `POS_LEFT)
      step_digit.dig[pos] = (up && d != `DIGIT_MAX) ? d + 4'h1 :
                            (!up && d != `DIGIT_ZERO) ? d - 4'h1 : d;
    else if (d == `DIGIT_ZERO && !(v.neg ^ up))
      step_digit.neg = ~up; // zero crossing flips the sign
    else if (!(v.neg ^ up))
      step_digit.dig[pos] = d - 4'h1; // magnitude toward zero
    else if (d != `DIGIT_MAX)
      step_digit.dig[pos] = d + 4'h1; // magnitude away from zero
  endfunction : step_digit

  // ************************************************************
  // key edges and decode
  // ************************************************************
  wire hima_pkg::hima_keys_t rise = key_lvl & ~key_prev_q;
  wire setup_long = setup_cnt_q == SW'(SETUP_LONG_CYC - 1);
  wire in_normal = o_state == hima_pkg::ST_NORMAL;
  wire in_level = o_state == hima_pkg::ST_LEVEL;
  wire in_pw = o_state == hima_pkg::ST_PASSWORD;
  wire in_menu = o_state == hima_pkg::ST_MENU;
  wire pw_submit = in_pw && ((rise.enter && (key_lvl.reset ||
                   o_flash_pos == `POS_LEFT)) || (rise.reset && key_lvl.enter));
  wire pw_restart = in_pw && rise.reset && !key_lvl.enter;
  wire pw_shift = in_pw && rise.enter && !key_lvl.reset &&
                  o_flash_pos != `POS_LEFT;
  wire pw_match = o_pw_entry == pw_q[o_level];
  wire at_end = o_item == last_item(o_menu);
  wire menu_fwd = in_menu && rise.down;
  wire menu_back = in_menu && rise.up;
  wire level_max = o_level == `LEVEL_THREE;
  wire level_min = o_level == `LEVEL_ONE;

  // key history and long press count
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      key_prev_q <= '0;
      setup_cnt_q <= '0;
    end
    else
    begin
      key_prev_q <= key_lvl;
      setup_cnt_q <= (in_normal && key_lvl.setup && !setup_long) ?
                     setup_cnt_q + 1'b1 : '0;
    end
  end

  // password store, loaded from the non-volatile copy or an edit
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      pw_q[1] <= `PW_USER_DEFAULT;
      pw_q[2] <= `PW_CAL_DEFAULT;
      pw_q[3] <= `PW_CFG_DEFAULT;
    end
    else if (i_pw_wr && i_pw_sel != 2'h0)
      pw_q[i_pw_sel] <= i_pw_value;
  end

  // ************************************************************
  // access sequencer
  // ************************************************************
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_state <= hima_pkg::ST_NORMAL;
      o_level <= `LEVEL_ONE;
      o_pw_entry <= `PW_PROMPT;
      o_flash_pos <= `POS_RIGHT;
      o_menu <= `MENU_USER;
      o_item <= 4'h0;
      o_item_select <= 1'b0;
      o_access_denied <= 1'b0;
    end
    else
    begin
      o_item_select <= in_menu && rise.enter;
      o_access_denied <= pw_submit && !pw_match;
      case (o_state)
        hima_pkg::ST_NORMAL:
          if (setup_long)
          begin
            o_state <= hima_pkg::ST_LEVEL;
            o_level <= `LEVEL_ONE;
          end
        hima_pkg::ST_LEVEL:
          if (rise.select)
          begin
            o_state <= hima_pkg::ST_PASSWORD;
            o_pw_entry <= `PW_PROMPT;
            o_flash_pos <= `POS_RIGHT;
          end
          else if (rise.up)
            o_level <= level_max ? `LEVEL_ONE : o_level + 2'h1;
          else if (rise.down)
            o_level <= level_min ? `LEVEL_THREE : o_level - 2'h1;
        hima_pkg::ST_PASSWORD:
          if (pw_submit)
          begin
            o_state <= pw_match ? hima_pkg::ST_MENU :
                       hima_pkg::ST_NORMAL;
            o_menu <= o_level;
            o_item <= 4'h0;
          end
          else if (pw_restart)
          begin
            o_pw_entry <= `PW_PROMPT;
            o_flash_pos <= `POS_RIGHT;
          end
          else if (pw_shift)
            o_flash_pos <= o_flash_pos + 3'h1;
          else if (rise.up || rise.down)
            o_pw_entry <= step_digit(o_pw_entry, o_flash_pos, rise.up);
        hima_pkg::ST_MENU:
          if (rise.setup)
            o_state <= hima_pkg::ST_NORMAL;
          else if (menu_fwd && at_end)
          begin
            o_menu <= (o_menu == `MENU_USER) ? o_level : o_menu - 2'h1;
            o_item <= 4'h0;
          end
          else if (menu_fwd)
            o_item <= o_item + 4'h1;
          else if (menu_back && o_item == 4'h0)
          begin
            o_menu <= (o_menu == o_level) ? `MENU_USER : o_menu + 2'h1;
            o_item <= last_item((o_menu == o_level) ? `MENU_USER :
                                o_menu + 2'h1);
          end
          else if (menu_back)
            o_item <= o_item - 4'h1;
        default:
          o_state <= hima_pkg::ST_NORMAL;
      endcase
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  chk_fast_freezes_both: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_analog_freeze |-> o_display_freeze)
    else $error("fast hold without display freeze");

  chk_long_press_entry: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (in_normal && setup_long) |=> (in_level && o_level == `LEVEL_ONE))
    else $error("long setup press did not open level prompt");

  chk_level_wraps: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (in_level && !rise.select && rise.up && level_max)
      |=> o_level == `LEVEL_ONE)
    else $error("level prompt did not wrap");

  sequence s_level_pick;
    in_level && rise.select;
  endsequence
  chk_password_prompt: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    s_level_pick |=> (in_pw && o_pw_entry == `PW_PROMPT &&
                      o_flash_pos == `POS_RIGHT))
    else $error("password prompt not cleared");

  chk_flash_moves_left: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    pw_shift |=> o_flash_pos == $past(o_flash_pos) + 3'h1)
    else $error("flash did not move left");

  sequence s_bad_submit;
    pw_submit && !pw_match;
  endsequence
  chk_bad_password: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    s_bad_submit |=> (in_normal && o_access_denied))
    else $error("wrong password not rejected");

  chk_config_to_cal: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (menu_fwd && !rise.setup && at_end && o_menu == `MENU_CFG)
      |=> (o_menu == `MENU_CAL && o_item == 4'h0))
    else $error("config menu did not lead into calibration");

  chk_default_password: assert property (
    @(posedge i_core_clk)
    $past(i_rst) |-> (pw_q[1] == `PW_USER_DEFAULT &&
                      pw_q[2] == `PW_CAL_DEFAULT &&
                      pw_q[3] == `PW_CFG_DEFAULT))
    else $error("password defaults wrong after reset");
endmodule : hima_core

// >>> core/hima_pkg.sv
// types shared by the hold inputs and menu access block
package hima_pkg;
  typedef enum logic [1:0]
  {
    ST_NORMAL = 2'h0,
    ST_LEVEL = 2'h1,
    ST_PASSWORD = 2'h3,
    ST_MENU = 2'h2
  } hima_state_t;

  typedef struct packed
  {
    logic setup;
    logic up;
    logic down;
    logic select;
    logic enter;
    logic reset;
  } hima_keys_t;

  typedef struct packed
  {
    logic mode;
    logic zero;
    logic limits;
    logic reset;
  } hima_ext_t;

  typedef struct packed
  {
    logic neg;
    logic [4:0][3:0] dig;
  } hima_pw_t;
endpackage : hima_pkg

// >>> core/hima_qual.sv
// two-flop synchroniser and stable-time qualifier for one pin
`timescale 1ns/1ps
module hima_qual #(
  parameter int unsigned QUAL_CYC = 16
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // pin and qualified level
  input wire logic i_pin,
  output logic o_level
);
  localparam int W = $clog2(QUAL_CYC + 1);
  logic meta_q;
  logic sync_q;
  logic [W-1:0] cnt_q;
  wire differs = sync_q != o_level;
  wire done = cnt_q == W'(QUAL_CYC - 1);

  // synchroniser, then level flips once stable long enough
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      cnt_q <= '0;
      o_level <= 1'b0;
    end
    else
    begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      cnt_q <= (differs && !done) ? cnt_q + 1'b1 : '0;
      if (differs && done)
        o_level <= sync_q;
    end
  end

  chk_level_after_count: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (o_level != $past(o_level)) |-> ($past(cnt_q) == W'(QUAL_CYC - 1)))
    else $error("qualified level changed before stable time");
endmodule : hima_qual

// >>> verif/hima_panel.sv
// keypad and opto line model driving the raw input pins
`timescale 1ns/1ps
module hima_panel (
  // clock
  input wire logic i_core_clk,
  // levels requested by the bench
  input wire logic [5:0] i_key_req,
  input wire logic [3:0] i_ext_req,
  input wire logic i_fast_req,
  // raw pins toward the block
  output hima_pkg::hima_keys_t o_keys,
  output hima_pkg::hima_ext_t o_ext,
  output logic o_fast
);
  // pins follow requests set on the falling edge, held as long as asked
  assign o_keys = i_key_req;
  assign o_ext = i_ext_req;
  assign o_fast = i_fast_req;
endmodule : hima_panel

// >>> verif/testbench.sv
// self-checking bench for the hold inputs and menu access block
`timescale 1ns/1ps
module testbench;
  localparam int K_SET = 5;
  localparam int K_UP = 4;
  localparam int K_DN = 3;
  localparam int K_SEL = 2;
  localparam int K_ENT = 1;
  localparam int K_RST = 0;
  logic clk;
  logic rst;
  logic [5:0] kreq;
  logic [3:0] ereq;
  logic freq;
  logic pw_wr;
  logic [1:0] pw_sel;
  hima_pkg::hima_pw_t pw_val;
  hima_pkg::hima_keys_t keys;
  hima_pkg::hima_ext_t ext;
  logic fast;
  hima_pkg::hima_ext_t ext_func;
  logic dfrz;
  logic afrz;
  hima_pkg::hima_state_t state;
  logic [1:0] level;
  hima_pkg::hima_pw_t pw_entry;
  logic [2:0] pos;
  logic [1:0] menu;
  logic [3:0] item;
  logic isel;
  logic deny;
  int mismatches = 0;
  int cmp_count = 0;
  int deny_n = 0;
  int isel_n = 0;

  // ********************
  // clock, parts
  // ********************
  // 25 MHz core clock
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // far side: keypad and opto lines
  hima_panel u_panel (.i_core_clk(clk), .i_key_req(kreq), .i_ext_req(ereq),
    .i_fast_req(freq), .o_keys(keys), .o_ext(ext), .o_fast(fast));
  // block with shortened counts
  hima_core #(.EXT_QUAL_CYC(8), .FAST_QUAL_CYC(4), .KEY_QUAL_CYC(4),
    .SETUP_LONG_CYC(16)) DUT (.i_core_clk(clk), .i_rst(rst),
    .i_keys(keys), .i_ext(ext), .i_ext_fast_hold(fast), .i_pw_wr(pw_wr),
    .i_pw_sel(pw_sel), .i_pw_value(pw_val), .o_ext_func(ext_func),
    .o_display_freeze(dfrz), .o_analog_freeze(afrz), .o_state(state),
    .o_level(level), .o_pw_entry(pw_entry), .o_flash_pos(pos),
    .o_menu(menu), .o_item(item), .o_item_select(isel),
    .o_access_denied(deny));
  // one-cycle pulses counted where they stand
  always @(posedge clk)
  begin
    if (deny === 1'h1) deny_n <= deny_n + 1;
    if (isel === 1'h1) isel_n <= isel_n + 1;
  end

  // ********************
  // shared tasks
  // ********************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic press(input int b);
    kreq[b] = 1'h1;
    cyc(10);
    kreq[b] = 1'h0;
    cyc(10);
  endtask : press
  // enter held, reset rises while it is held
  task automatic both;
    kreq[K_ENT] = 1'h1;
    cyc(10);
    kreq[K_RST] = 1'h1;
    cyc(10);
    kreq = 6'h00;
    cyc(10);
  endtask : both
  task automatic long_setup;
    kreq[K_SET] = 1'h1;
    cyc(40);
    kreq[K_SET] = 1'h0;
    cyc(10);
  endtask : long_setup
  task automatic stop_test;
    $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // ********************
  // scenarios
  // ********************
  // short pulses ignored, long ones act in time on each line
  task automatic t_ext;
    for (int b = 0; b < 4; b++)
    begin
      ereq[b] = 1'h1;
      cyc(3);
      ereq[b] = 1'h0;
      cyc(20);
      chk(ext_func[b], 1'h0);
      ereq[b] = 1'h1;
      cyc(14);
      chk(ext_func[b], 1'h1);
      ereq[b] = 1'h0;
      cyc(14);
      chk(ext_func[b], 1'h0);
    end
  endtask : t_ext
  // fast hold with digital hold raised together
  task automatic t_hold;
    freq = 1'h1;
    cyc(2);
    freq = 1'h0;
    cyc(12);
    chk(afrz, 1'h0);
    freq = 1'h1;
    ereq[0] = 1'h1;
    cyc(8);
    chk({dfrz, afrz}, 2'h3);
    freq = 1'h0;
    cyc(8);
    chk({dfrz, afrz}, 2'h2);
    ereq[0] = 1'h0;
    cyc(14);
    chk(dfrz, 1'h0);
  endtask : t_hold
  // top level access and run-on through all three menus
  task automatic t_cfg;
    long_setup;
    chk(state, hima_pkg::ST_LEVEL);
    chk(level, 2'h1);
    press(K_UP);
    press(K_UP);
    chk(level, 2'h3);
    press(K_UP);
    chk(level, 2'h1);
    press(K_DN);
    chk(level, 2'h3);
    press(K_SEL);
    chk(state, hima_pkg::ST_PASSWORD);
    chk({pw_entry, pos}, 24'h0);
    repeat (3) press(K_UP);
    chk(pw_entry, 21'h000003);
    both;
    chk({state, menu, item}, {hima_pkg::ST_MENU, 2'h3, 4'h0});
    press(K_DN);
    chk(item, 4'h1);
    press(K_UP);
    chk(item, 4'h0);
    press(K_ENT);
    chk(24'(isel_n), 24'h1);
    repeat (4) press(K_DN);
    chk({menu, item}, {2'h2, 4'h0});
    repeat (8) press(K_DN);
    chk({menu, item}, {2'h1, 4'h0});
    press(K_UP);
    chk({menu, item}, {2'h2, 4'h7});
    press(K_SET);
    chk(state, hima_pkg::ST_NORMAL);
  endtask : t_cfg
  // defaults of the two lower levels
  task automatic t_lvl;
    for (int l = 1; l < 3; l++)
    begin
      long_setup;
      repeat (l - 1) press(K_UP);
      press(K_SEL);
      repeat (l) press(K_UP);
      both;
      chk({state, menu}, {hima_pkg::ST_MENU, l[1:0]});
      press(K_SET);
    end
  endtask : t_lvl
  // reloaded negative password: old value refused, new one by enter steps
  task automatic t_pw;
    pw_sel = 2'h1;
    pw_val = 21'h100012;
    pw_wr = 1'h1;
    cyc(1);
    pw_wr = 1'h0;
    cyc(2);
    long_setup;
    press(K_SEL);
    press(K_UP);
    both;
    chk(24'(deny_n), 24'h1);
    chk(state, hima_pkg::ST_NORMAL);
    long_setup;
    press(K_SEL);
    press(K_UP);
    press(K_RST);
    chk({pw_entry, pos}, 24'h0);
    press(K_UP);
    press(K_UP);
    press(K_ENT);
    chk(pos, 3'h1);
    press(K_UP);
    chk(pw_entry, 21'h000012);
    repeat (3) press(K_ENT);
    chk(pos, 3'h4);
    press(K_UP);
    chk(pw_entry, 21'h010012);
    press(K_DN);
    press(K_DN);
    chk(pw_entry, 21'h100012);
    press(K_ENT);
    chk({state, menu}, {hima_pkg::ST_MENU, 2'h1});
    press(K_SET);
  endtask : t_pw

  // ********************
  // main sequence, watchdog
  // ********************
  initial
  begin
    rst = 1'h1;
    kreq = 6'h00;
    ereq = 4'h0;
    freq = 1'h0;
    pw_wr = 1'h0;
    pw_sel = 2'h0;
    pw_val = 21'h0;
    cyc(6);
    rst = 1'h0;
    cyc(2);
    chk({state, level, menu, dfrz, afrz}, 8'h14);
    t_ext;
    t_hold;
    t_cfg;
    t_lvl;
    t_pw;
    stop_test;
  end
  // hang guard
  initial
  begin
    repeat (9000) @(posedge clk);
    mismatches++;
    stop_test;
  end
endmodule : testbench
